// >>> tim_timer_end.sv
// Timer end: counter, captures, event flags, flag clearing and the
// merged request line. Assumes byte strobes one cycle wide from the link
// and synchronous pin inputs; count_tick is a one-cycle enable.
`timescale 1ns/1ps
`default_nettype none
`include "tim_defs.svh"

// Operation
// - Five events share one request line
// - Software sets priority, then rising trigger
// - Software selects timer as channel source
// - Each event group gated by its enable
// - Software clears pending before unmasking channel
// - One capture enable covers both captures
// - New edge only after all flags zero
// - Handler loops until status reads zero
// - Status access arms, low byte clears
// - Software uses byte accesses only
// - Control, status and six data pairs
// - Capture one loads counter into pair
// - Capture two loads counter into pair
// - Counter high byte read-only, resets FFh
// - Counter low resets FCh; write resets counter
// - Counter low after status clears overflow
// - Mirror high byte read-only, resets FFh
// - Overflow flag set on wrap to zero
// - Mirror low access never clears overflow
// - Source select picks pin or timer
// - Control one bits 7,6,5 enable groups
module tim_timer_end (
  input  wire logic       clk,
  input  wire logic       rst,
  tim_link_if.timer_end   link,
  input  wire logic       count_tick,
  input  wire logic       capture_pin_one,
  input  wire logic       capture_pin_two,
  input  wire logic       compare_one_match,
  input  wire logic       compare_two_match,
  input  wire logic       ext_irq_pin,
  output logic [15:0]     count_value
);

  tim_pkg::tim_dev_state_type s;
  tim_pkg::tim_dev_state_type next_s;

  logic       access;
  logic       status_acc;
  logic       edge_one;
  logic       edge_two;
  logic [4:0] set_flags;
  logic [4:0] clr_flags;
  logic [4:0] new_flags;
  logic       en_any;

  // All behaviour in one next-state pass
  always_comb
  begin
    next_s = s;
    next_s.ack = 1'b0;
    access = link.reg_rd | link.reg_wr;
    status_acc = access && (link.reg_addr == `TIM_ADDR_STATUS);
    set_flags = 5'h00;
    clr_flags = 5'h00;

    // Pin history for edge detection
    next_s.pin_one_q = capture_pin_one;
    next_s.pin_two_q = capture_pin_two;
    edge_one = s.ctrl1[`TIM_CTRL1_CAP1_EDGE]
             ? (capture_pin_one & ~s.pin_one_q)
             : (~capture_pin_one & s.pin_one_q);
    edge_two = s.ctrl2[`TIM_CTRL2_CAP2_EDGE]
             ? (capture_pin_two & ~s.pin_two_q)
             : (~capture_pin_two & s.pin_two_q);

    if (edge_one)
    begin
      next_s.cap_one = s.count;
      set_flags[`TIM_FLAG_CAP1] = 1'b1;
    end
    if (edge_two)
    begin
      next_s.cap_two = s.count;
      set_flags[`TIM_FLAG_CAP2] = 1'b1;
    end
    set_flags[`TIM_FLAG_CMP1] = compare_one_match;
    set_flags[`TIM_FLAG_CMP2] = compare_two_match;

    // Free running counter
    if (count_tick)
    begin
      next_s.count = s.count + 16'h0001;
      if (s.count == `TIM_COUNT_MAX)
        set_flags[`TIM_FLAG_OVF] = 1'b1;
    end

    if (status_acc)
      next_s.armed = s.flags;

    // Register access decode and side effects
    if (access)
    begin
      next_s.ack = 1'b1;
      next_s.rdata = `TIM_REG_RESET;
      unique case (link.reg_addr)
        `TIM_ADDR_CAP1_HIGH: next_s.rdata = s.cap_one[15:8];
        `TIM_ADDR_CAP1_LOW:
        begin
          next_s.rdata = s.cap_one[7:0];
          clr_flags[`TIM_FLAG_CAP1] = s.armed[`TIM_FLAG_CAP1];
        end
        `TIM_ADDR_CAP2_HIGH: next_s.rdata = s.cap_two[15:8];
        `TIM_ADDR_CAP2_LOW:
        begin
          next_s.rdata = s.cap_two[7:0];
          clr_flags[`TIM_FLAG_CAP2] = s.armed[`TIM_FLAG_CAP2];
        end
        `TIM_ADDR_COUNT_HIGH: next_s.rdata = s.count[15:8];
        `TIM_ADDR_COUNT_LOW:
        begin
          next_s.rdata = s.count[7:0];
          clr_flags[`TIM_FLAG_OVF] = s.armed[`TIM_FLAG_OVF];
          if (link.reg_wr)
            next_s.count = `TIM_COUNT_RESET;
        end
        `TIM_ADDR_MIRROR_HIGH: next_s.rdata = s.count[15:8];
        `TIM_ADDR_MIRROR_LOW:
        begin
          next_s.rdata = s.count[7:0];
          if (link.reg_wr)
            next_s.count = `TIM_COUNT_RESET;
        end
        `TIM_ADDR_CMP1_LOW:
          clr_flags[`TIM_FLAG_CMP1] = s.armed[`TIM_FLAG_CMP1];
        `TIM_ADDR_CMP2_LOW:
          clr_flags[`TIM_FLAG_CMP2] = s.armed[`TIM_FLAG_CMP2];
        `TIM_ADDR_CTRL1:
        begin
          next_s.rdata = s.ctrl1;
          if (link.reg_wr)
            next_s.ctrl1 = link.reg_wdata;
        end
        `TIM_ADDR_CTRL2:
        begin
          next_s.rdata = s.ctrl2;
          if (link.reg_wr)
            next_s.ctrl2 = link.reg_wdata;
        end
        `TIM_ADDR_STATUS: next_s.rdata = {s.flags, 3'b000};
        `TIM_ADDR_CTRL3:
        begin
          next_s.rdata = {7'h00, s.ctrl3_sel};
          if (link.reg_wr)
            next_s.ctrl3_sel = link.reg_wdata[`TIM_CTRL3_SRC_SEL];
        end
        default: next_s.rdata = `TIM_REG_RESET;
      endcase
    end

    // Used arms drop; a flag set this cycle survives its clear
    next_s.armed = next_s.armed & ~clr_flags;
    new_flags = (s.flags & ~clr_flags) | set_flags;
    next_s.flags = new_flags;

    en_any = (s.ctrl1[`TIM_CTRL1_CAP_IE]
              & (new_flags[`TIM_FLAG_CAP1] | new_flags[`TIM_FLAG_CAP2]))
           | (s.ctrl1[`TIM_CTRL1_CMP_IE]
              & (new_flags[`TIM_FLAG_CMP1] | new_flags[`TIM_FLAG_CMP2]))
           | (s.ctrl1[`TIM_CTRL1_OVF_IE] & new_flags[`TIM_FLAG_OVF]);

    // drop only when all flags zero
    next_s.req_level = en_any | (s.req_level & (|new_flags));

    next_s.channel_req = s.ctrl3_sel ? s.req_level : ext_irq_pin;
    next_s.count_out = next_s.count;
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.count <= `TIM_COUNT_RESET;
      s.count_out <= `TIM_COUNT_RESET;
    end
    else
      s <= next_s;
  end

  // Outputs straight from state
  assign link.reg_rdata   = s.rdata;
  assign link.reg_ack     = s.ack;
  assign link.channel_req = s.channel_req;
  assign count_value      = s.count_out;

endmodule : tim_timer_end

`default_nettype wire

// >>> tim_defs.svh
// Offsets, field positions, reset values and host word indices for the timer block.
// Assumes byte-wide timer registers and a word-indexed host register map.
`ifndef TIM_DEFS_SVH
`define TIM_DEFS_SVH

// Timer byte register offsets
`define TIM_ADDR_CAP1_HIGH   8'hF0
`define TIM_ADDR_CAP1_LOW    8'hF1
`define TIM_ADDR_CAP2_HIGH   8'hF2
`define TIM_ADDR_CAP2_LOW    8'hF3
`define TIM_ADDR_COUNT_HIGH  8'hF4
`define TIM_ADDR_COUNT_LOW   8'hF5
`define TIM_ADDR_MIRROR_HIGH 8'hF6
`define TIM_ADDR_MIRROR_LOW  8'hF7
`define TIM_ADDR_CMP1_LOW    8'hF9
`define TIM_ADDR_CMP2_LOW    8'hFB
`define TIM_ADDR_CTRL1       8'hFC
`define TIM_ADDR_CTRL2       8'hFD
`define TIM_ADDR_STATUS      8'hFE
`define TIM_ADDR_CTRL3       8'hFF

// Reset values and counter maximum
`define TIM_COUNT_RESET      16'hFFFC
`define TIM_COUNT_MAX        16'hFFFF
`define TIM_REG_RESET        8'h00

// Control register one fields
`define TIM_CTRL1_CAP_IE     7
`define TIM_CTRL1_CMP_IE     6
`define TIM_CTRL1_OVF_IE     5
`define TIM_CTRL1_CAP1_EDGE  1
// Control register two and three fields
`define TIM_CTRL2_CAP2_EDGE  1
`define TIM_CTRL3_SRC_SEL    0

// Flag positions inside the five-bit flag vector (status bits 7..3)
`define TIM_FLAG_CAP1        4
`define TIM_FLAG_CMP1        3
`define TIM_FLAG_OVF         2
`define TIM_FLAG_CAP2        1
`define TIM_FLAG_CMP2        0

// Interrupt channel register word indices and timer forward nibble on the host bus
`define TIM_CH_TRIGGER       8'h00
`define TIM_CH_PENDING       8'h01
`define TIM_CH_MASK          8'h02
`define TIM_CH_PRIORITY      8'h03
`define TIM_FWD_NIBBLE       4'hF

`endif

// >>> tim_pkg.sv
// Types shared by both ends of the timer link.
// Assumes tim_defs.svh for all numeric constants.
`default_nettype none

package tim_pkg;

  // Timer end state
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] count_out;
    logic [15:0] cap_one;
    logic [15:0] cap_two;
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic        ctrl3_sel;
    logic [4:0]  flags;
    logic [4:0]  armed;
    logic        pin_one_q;
    logic        pin_two_q;
    logic        req_level;
    logic        channel_req;
    logic [7:0]  rdata;
    logic        ack;
  } tim_dev_state_type;

  // Host bus sequencer
  typedef enum logic [1:0] {
    st_idle,
    st_fwd,
    st_done
  } tim_seq_type;

  // Interrupt channel end state
  typedef struct packed {
    tim_seq_type seq;
    logic        waitreq;
    logic [31:0] rdata;
    logic        trig_rising;
    logic        pending;
    logic        mask;
    logic [2:0]  prio;
    logic        req_q;
    logic        irq;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } tim_ch_state_type;

endpackage : tim_pkg

`default_nettype wire

// >>> tim_link_if.sv
// Link between the timer end and the interrupt channel end.
// Assumes one common clock; both ends drive only their own signals.
`timescale 1ns/1ps
`default_nettype none

interface tim_link_if;
  logic [7:0] reg_addr;
  logic       reg_rd;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_ack;
  logic       channel_req;

  modport timer_end (
    input  reg_addr,
    input  reg_rd,
    input  reg_wr,
    input  reg_wdata,
    output reg_rdata,
    output reg_ack,
    output channel_req
  );

  modport channel_end (
    output reg_addr,
    output reg_rd,
    output reg_wr,
    output reg_wdata,
    input  reg_rdata,
    input  reg_ack,
    input  channel_req
  );
endinterface : tim_link_if

`default_nettype wire

// >>> tim_irq_channel.sv
// Interrupt channel end: edge trigger, pending, mask, priority, and an
// Avalon-MM slave that also forwards byte accesses to the timer end.
// Assumes the timer end acknowledges each strobe within a few cycles.
`timescale 1ns/1ps
`default_nettype none
`include "tim_defs.svh"

module tim_irq_channel (
  input  wire logic        clk,
  input  wire logic        rst,
  tim_link_if.channel_end  link,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  output logic [2:0]       priority_level
);

  tim_pkg::tim_ch_state_type s;
  tim_pkg::tim_ch_state_type next_s;

  logic req;
  logic fwd;
  logic edge_seen;
  logic own_wr;

  // Trigger, pending and bus sequencing
  always_comb
  begin
    next_s = s;
    next_s.rd = 1'b0;
    next_s.wr = 1'b0;
    req = avs_read | avs_write;
    fwd = (avs_address[7:4] == `TIM_FWD_NIBBLE);
    own_wr = 1'b0;

    next_s.req_q = link.channel_req;
    edge_seen = s.trig_rising ? (link.channel_req & ~s.req_q)
                              : (~link.channel_req & s.req_q);

    unique case (s.seq)
      tim_pkg::st_idle:
        if (req && fwd)
        begin
          next_s.addr = avs_address;
          next_s.wdata = avs_writedata[7:0];
          next_s.rd = avs_read;
          next_s.wr = avs_write;
          next_s.seq = tim_pkg::st_fwd;
        end
        else if (req)
        begin
          next_s.rdata = 32'h0000_0000;
          unique case (avs_address)
            `TIM_CH_TRIGGER:  next_s.rdata[0] = s.trig_rising;
            `TIM_CH_PENDING:  next_s.rdata[0] = s.pending;
            `TIM_CH_MASK:     next_s.rdata[0] = s.mask;
            `TIM_CH_PRIORITY: next_s.rdata[2:0] = s.prio;
            default:          next_s.rdata = 32'h0000_0000;
          endcase
          next_s.waitreq = 1'b0;
          next_s.seq = tim_pkg::st_done;
        end
      tim_pkg::st_fwd:
        if (link.reg_ack)
        begin
          next_s.rdata = {24'h00_0000, link.reg_rdata};
          next_s.waitreq = 1'b0;
          next_s.seq = tim_pkg::st_done;
        end
      tim_pkg::st_done:
      begin
        // Write lands at the edge the master sees waitrequest low
        own_wr = avs_write & ~fwd;
        next_s.waitreq = 1'b1;
        next_s.seq = tim_pkg::st_idle;
      end
      default: next_s.seq = tim_pkg::st_idle;
    endcase

    if (own_wr)
    begin
      unique case (avs_address)
        `TIM_CH_TRIGGER:  next_s.trig_rising = avs_writedata[0];
        `TIM_CH_MASK:     next_s.mask = avs_writedata[0];
        `TIM_CH_PRIORITY: next_s.prio = avs_writedata[2:0];
        default:          next_s.prio = s.prio;
      endcase
    end

    // software clears pending; new edge wins
    if (own_wr && avs_address == `TIM_CH_PENDING)
      next_s.pending = avs_writedata[0] | edge_seen;
    else
      next_s.pending = s.pending | edge_seen;

    // Core sees pending only while unmasked
    next_s.irq = next_s.pending & next_s.mask;
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.seq <= tim_pkg::st_idle;
      s.waitreq <= 1'b1;
    end
    else
      s <= next_s;
  end

  // Outputs straight from state
  assign link.reg_addr   = s.addr;
  assign link.reg_rd     = s.rd;
  assign link.reg_wr     = s.wr;
  assign link.reg_wdata  = s.wdata;
  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign irq             = s.irq;
  assign priority_level  = s.prio;

endmodule : tim_irq_channel

`default_nettype wire

// >>> tim_link_checker.sv
// Checker on the link between timer end and channel end.
// Assumes one clock and the active high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "tim_defs.svh"

module tim_link_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_ack,
  input wire logic       channel_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Strobe and answer pairing
  ack_follows_a: assert property ((reg_rd || reg_wr) |=> reg_ack)
    else $error("no answer one cycle after strobe");
  ack_cause_a: assert property (reg_ack |-> $past(reg_rd || reg_wr))
    else $error("answer without strobe");
  strobe_single_a: assert property (reg_rd |=> !reg_rd [*2])
    else $error("read strobe longer than one byte access");
  strobe_excl_a: assert property (!(reg_rd && reg_wr))
    else $error("read and write strobes together");
  hold_data_a: assert property (!reg_ack |-> $stable(reg_rdata))
    else $error("read byte changed without answer");

  // Fixed read values
  status_low_a: assert property (
    reg_rd && reg_addr == `TIM_ADDR_STATUS |=> reg_rdata[2:0] == 3'h0)
    else $error("reserved status bits not zero");
  sel_upper_a: assert property (
    reg_rd && reg_addr == `TIM_ADDR_CTRL3 |=> reg_rdata[7:1] == 7'h00)
    else $error("unused select bits not zero");
  cmp_low_a: assert property (
    reg_rd && reg_addr == `TIM_ADDR_CMP1_LOW |=> reg_ack && reg_rdata == 8'h00)
    else $error("compare low byte not zero");

  // Main scenarios
  cover property ($rose(channel_req));
  cover property (reg_wr && reg_addr == `TIM_ADDR_COUNT_LOW);
  cover property (reg_wr && reg_addr == `TIM_ADDR_CTRL3 && reg_wdata[0]);
endmodule : tim_link_checker

`default_nettype wire

// >>> tb_timer_irq_merge_and_count_regs.sv
// Bench joining timer end and channel end over the link.
// Assumes Avalon answers come within fifty cycles.
`timescale 1ns/1ps
`default_nettype none

module tb_timer_irq_merge_and_count_regs;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tick = 1'b0;
  logic        pin1 = 1'b0;
  logic        pin2 = 1'b1;
  logic        m1 = 1'b0;
  logic        m2 = 1'b0;
  logic        ext = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic        irq;
  logic [2:0]  prio;
  logic [15:0] cnt;
  logic [7:0]  rv;
  int          mismatches = 0;
  int          cmp_count = 0;

  // Clock
  always #2 clk = ~clk;

  tim_link_if link ();
  tim_timer_end tim_timer_end_i (.clk(clk), .rst(rst), .link(link),
    .count_tick(tick), .capture_pin_one(pin1), .capture_pin_two(pin2),
    .compare_one_match(m1), .compare_two_match(m2), .ext_irq_pin(ext),
    .count_value(cnt));
  tim_irq_channel tim_irq_channel_i (.clk(clk), .rst(rst), .link(link),
    .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .irq(irq), .priority_level(prio));
  tim_link_checker tim_link_checker_i (.clk(clk), .rst(rst),
    .reg_addr(link.reg_addr), .reg_rd(link.reg_rd), .reg_wr(link.reg_wr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .reg_ack(link.reg_ack), .channel_req(link.channel_req));

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      mismatches++;
      $display("wrong value at %0t: bus answer timed out", $time);
      close_out;
    end
    rv = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic ck(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(rv, e);
  endtask : ck

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask : put

  // One match pulse; lowers only the line it raised
  task automatic hit(input int which);
    if (which == 1)
      m1 <= 1'b1;
    else
      m2 <= 1'b1;
    @(posedge clk);
    if (which == 1)
      m1 <= 1'b0;
    else
      m2 <= 1'b0;
  endtask : hit

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, irq}, 8'h01);
  endtask : wait_irq

  task automatic t_reset;
    ck(8'hF4, 8'hFF);
    ck(8'hF5, 8'hFC);
    ck(8'hF6, 8'hFF);
    ck(8'hFE, 8'h00);
    put(8'hF4, 8'h12);
    ck(8'hF4, 8'hFF);
    ck(8'h40, 8'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_setup;
    put(8'h03, 8'h05);
    chk({5'h0, prio}, 8'h05);
    put(8'h00, 8'h01);
    put(8'hFF, 8'h01);
    ck(8'hFF, 8'h01);
    put(8'hFC, 8'hE0);
    put(8'h01, 8'h00);
    put(8'h02, 8'h01);
    $display("setup test done");
  endtask : t_setup

  task automatic t_compare;
    hit(1);
    wait_irq;
    ck(8'hFE, 8'h40);
    hit(2);
    ck(8'hF9, 8'h00);
    ck(8'hFE, 8'h08);
    put(8'h01, 8'h00);
    hit(1);
    repeat (10) @(posedge clk);
    ck(8'h01, 8'h00);
    ck(8'hFE, 8'h48);
    ck(8'hF9, 8'h00);
    ck(8'hFB, 8'h00);
    ck(8'hFE, 8'h00);
    put(8'h01, 8'h00);
    hit(1);
    wait_irq;
    ck(8'hFE, 8'h40);
    ck(8'hF9, 8'h00);
    put(8'h01, 8'h00);
    put(8'hFC, 8'h20);
    hit(1);
    repeat (10) @(posedge clk);
    ck(8'h01, 8'h00);
    ck(8'hFE, 8'h40);
    ck(8'hF9, 8'h00);
    $display("compare test done");
  endtask : t_compare

  task automatic t_capture;
    put(8'hFC, 8'h82);
    put(8'hF5, 8'h00);
    pin2 <= 1'b0;
    wait_irq;
    ck(8'hF2, 8'hFF);
    ck(8'hF3, 8'hFC);
    tick <= 1'b1;
    repeat (2) @(posedge clk);
    tick <= 1'b0;
    pin1 <= 1'b1;
    repeat (3) @(posedge clk);
    chk(cnt[7:0], 8'hFE);
    ck(8'hF0, 8'hFF);
    ck(8'hF1, 8'hFE);
    ck(8'hFE, 8'h90);
    ck(8'hF1, 8'hFE);
    ck(8'hF3, 8'hFC);
    ck(8'hFE, 8'h00);
    put(8'h01, 8'h00);
    $display("capture test done");
  endtask : t_capture

  task automatic t_overflow;
    put(8'hF5, 8'h00);
    tick <= 1'b1;
    repeat (4) @(posedge clk);
    tick <= 1'b0;
    ck(8'hF6, 8'h00);
    ck(8'hF4, 8'h00);
    ck(8'hFE, 8'h20);
    ck(8'hF7, 8'h00);
    ck(8'hFE, 8'h20);
    ck(8'hF5, 8'h00);
    ck(8'hFE, 8'h00);
    put(8'hFF, 8'h00);
    put(8'h01, 8'h00);
    ext <= 1'b1;
    wait_irq;
    $display("overflow test done");
  endtask : t_overflow

  // handler loop until status reads zero
  task automatic service;
    int         n;
    logic [7:0] st;
    n = 0;
    bus(8'hFE, 1'b0, 8'h00);
    st = rv;
    while (st != 8'h00 && n < 8)
    begin
      if (st[7])
        bus(8'hF1, 1'b0, 8'h00);
      if (st[4])
        bus(8'hF3, 1'b0, 8'h00);
      if (st[6])
        bus(8'hF9, 1'b0, 8'h00);
      if (st[3])
        bus(8'hFB, 1'b1, 8'h00);
      if (st[5])
        bus(8'hF5, 1'b0, 8'h00);
      bus(8'hFE, 1'b0, 8'h00);
      st = rv;
      n++;
    end
    chk(st, 8'h00);
  endtask : service

  task automatic t_handler;
    put(8'hFC, 8'h40);
    put(8'h01, 8'h00);
    hit(1);
    hit(2);
    wait_irq;
    service;
    put(8'h01, 8'h00);
    chk({7'h0, irq}, 8'h00);
    hit(2);
    wait_irq;
    service;
    put(8'h01, 8'h00);
    $display("handler test done");
  endtask : t_handler

  task automatic t_regs;
    put(8'hF7, 8'h00);
    ck(8'hF5, 8'hFC);
    ck(8'hF7, 8'hFC);
    put(8'hFD, 8'h02);
    ck(8'hFD, 8'h02);
    ck(8'h00, 8'h01);
    ck(8'h02, 8'h01);
    ck(8'h03, 8'h05);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    ck(8'hF5, 8'hFC);
    ck(8'hFD, 8'h00);
    ck(8'h03, 8'h00);
    ck(8'hFE, 8'h00);
    $display("register and reset test done");
  endtask : t_regs

  // Reset, then the scenarios in order
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_setup;
    t_compare;
    t_capture;
    t_handler;
    t_overflow;
    t_regs;
    close_out;
  end

  // Watchdog
  initial
  begin
    #100000;
    mismatches++;
    close_out;
  end
endmodule : tb_timer_irq_merge_and_count_regs

`default_nettype wire
